// ---- core/pdrc_pkg.sv ----
// constants shared by the power-down and reset control block
// assumes one 100 MHz clock and an 8-bit paged register port
`default_nettype none

package pdrc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int NREG    = 16;
  localparam int NOUT    = 12;
  localparam int NIN     = 4;
  localparam logic [7:0] PAGE_OFS = 8'h01;

  localparam logic [3:0] IDX_SLEEP = 4'h0;
  localparam logic [3:0] IDX_OUT0A = 4'h1;
  localparam logic [3:0] IDX_ALL   = 4'hD;
  localparam logic [3:0] IDX_XO    = 4'hE;
  localparam logic [3:0] IDX_INEN  = 4'hF;
  localparam logic [3:0] IDX_LAST  = 4'hF;

  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'h001E, 16'h0103, 16'h0108, 16'h010D, 16'h0112, 16'h0117,
    16'h011C, 16'h0121, 16'h0126, 16'h012B, 16'h0130, 16'h0135,
    16'h013A, 16'h0145, 16'h090E, 16'h0949};

  // nvm bank burn command register and key
  localparam logic [15:0] BURN_ADDR = 16'h00E3;
  localparam logic [7:0]  BURN_KEY  = 8'h5A;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SLEEP_BIT    = 0;
  localparam int HARD_RST_BIT = 1;
  localparam int DRV_OFF_BIT  = 0;
  localparam int ALL_OFF_BIT  = 0;
  localparam int XO_EN_BIT    = 1;
  localparam int IN_EN_LSB    = 0;

  // ---------------------------------------------------------------
  // base part image and fixed base settings
  // ---------------------------------------------------------------
  localparam logic [7:0] BASE_IMAGE [NREG] = '{
    8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
    8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h0F};
  localparam logic [7:0] XTAL_MHZ = 8'h30;
  localparam logic       IO_1V8   = 1'b1;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PDRC_LOAD  = 2'b00,
    PDRC_ALIGN = 2'b01,
    PDRC_RUN   = 2'b10
  } pdrc_state_t;

endpackage

`default_nettype wire

// ---- core/pdrc_nvm.sv ----
// non-volatile image of the power control registers
// assumes burn is a one-cycle pulse and live holds the register file
`default_nettype none

module pdrc_nvm #(
  parameter bit FACTORY = 1'b0,
  parameter logic [7:0] FACTORY_IMAGE [pdrc_pkg::NREG] = pdrc_pkg::BASE_IMAGE
) (
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               burn,
  input  wire logic [pdrc_pkg::NREG-1:0][7:0]     live,
  input  wire logic [3:0]                         rd_idx,
  output logic      [7:0]                         rd_data
);

  typedef struct packed {
    logic [pdrc_pkg::NREG-1:0][7:0] image;
  } pdrc_nvm_st_t;

  pdrc_nvm_st_t s;
  pdrc_nvm_st_t next_s;

  // burn copies the live registers into the image
  always_comb begin
    next_s = s;
    if (burn) begin
      next_s.image = live;
    end
  end

  // image holds the part's contents from power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < pdrc_pkg::NREG; i++) begin
        s.image[i] <= FACTORY ? FACTORY_IMAGE[i]
                              : pdrc_pkg::BASE_IMAGE[i];
      end
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.image[rd_idx];

endmodule

`default_nettype wire

// ---- core/pdrc_hard_req.sv ----
// hard reset request from the reset pin or the register bit
// assumes the pin is synchronous to clk_sys
`default_nettype none

module pdrc_hard_req (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic reset_pin_low,
  input  wire logic bit_strobe,
  output logic      req
);

  typedef struct packed {
    logic req;
  } pdrc_req_st_t;

  pdrc_req_st_t s;
  pdrc_req_st_t next_s;

  // held while the pin is low, one cycle for the bit
  always_comb begin
    next_s     = s;
    next_s.req = !reset_pin_low || bit_strobe;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign req = s.req;

endmodule

`default_nettype wire

// ---- core/pdrc_top.sv ----
// power-down and reset control: paged register port, nvm reload,
// output realign and power-down controls
// assumes a synchronous host port and one 100 MHz clock
// hazards: a hard reset drops unsaved writes, and requests made while
// a load runs get no answer, so the host must watch load_busy
`default_nettype none

module pdrc_top #(
  parameter bit FACTORY = 1'b0,
  parameter logic [7:0] FACTORY_IMAGE [pdrc_pkg::NREG] = pdrc_pkg::BASE_IMAGE
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      reset_pin_low,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_ack,
  output logic                           device_sleep_ctl,
  output logic      [pdrc_pkg::NOUT-1:0] driver_off,
  output logic                           xo_power,
  output logic      [pdrc_pkg::NIN-1:0]  in_buf_en,
  output logic                           realign,
  output logic                           load_busy,
  output logic      [7:0]                xtal_mhz,
  output logic                           io_1v8
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // map sizes the decode and the load counter are built for
  if (pdrc_pkg::NOUT != 12) begin : g_bad_nout
    $error("pdrc_top: driver count not supported");
  end
  if (pdrc_pkg::NIN != 4) begin : g_bad_nin
    $error("pdrc_top: input buffer count not supported");
  end
  if (pdrc_pkg::NREG != 16) begin : g_bad_nreg
    $error("pdrc_top: register count not supported");
  end
  // load counter wraps on the last index
  if (pdrc_pkg::IDX_LAST != pdrc_pkg::NREG - 1) begin : g_bad_last
    $error("pdrc_top: last load index does not match map");
  end
  // drivers sit at consecutive indices just below the global bit
  if (pdrc_pkg::IDX_ALL - pdrc_pkg::IDX_OUT0A !=
      pdrc_pkg::NOUT) begin : g_bad_idx
    $error("pdrc_top: driver indices do not match map");
  end
  // enable field must fit in one register byte
  if (pdrc_pkg::IN_EN_LSB + pdrc_pkg::NIN > 8) begin : g_bad_inen
    $error("pdrc_top: input enable field too wide");
  end
  // a stored hard reset strobe would read back as set
  if (FACTORY &&
      FACTORY_IMAGE[pdrc_pkg::IDX_SLEEP][pdrc_pkg::HARD_RST_BIT])
  begin : g_bad_image
    $error("pdrc_top: factory image holds the hard reset bit");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pdrc_pkg::pdrc_state_t           state;
    logic [3:0]                      idx;
    logic [7:0]                      page;
    logic [pdrc_pkg::NREG-1:0][7:0]  regs;
    logic [7:0]                      rdata;
    logic                            ack;
    logic                            burn;
    logic                            hard_bit;
    logic                            sleep;
    logic [pdrc_pkg::NOUT-1:0]       drv_off;
    logic                            xo_pwr;
    logic [pdrc_pkg::NIN-1:0]        in_en;
    logic                            realign;
    logic                            busy;
    logic [7:0]                      xtal;
    logic                            io18;
  } pdrc_top_st_t;

  pdrc_top_st_t s;
  pdrc_top_st_t next_s;

  logic       hard_req;
  logic [7:0] nvm_data;
  logic [4:0] wr_dec;
  logic [4:0] rd_dec;
  logic [15:0] full_addr;
  logic       burn_hit;

  // ---------------------------------------------------------------
  // address decode: {hit, index}
  // ---------------------------------------------------------------
  function automatic logic [4:0] pdrc_decode(input logic [15:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < pdrc_pkg::NREG; i++) begin
      if (a == pdrc_pkg::REG_ADDR[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // page register answers at offset 1 of every page
  function automatic logic pdrc_is_page(input logic [7:0] a);
    return (a == pdrc_pkg::PAGE_OFS);
  endfunction

  // page selects the upper address byte
  assign full_addr = {s.page, reg_addr};
  assign wr_dec    = pdrc_decode(full_addr);
  assign rd_dec    = pdrc_decode(full_addr);
  // burn command has no storage, so it stays out of the map
  assign burn_hit  = (full_addr == pdrc_pkg::BURN_ADDR);

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  pdrc_nvm #(
    .FACTORY       (FACTORY),
    .FACTORY_IMAGE (FACTORY_IMAGE)
  ) u_nvm (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .burn    (s.burn),
    .live    (s.regs),
    .rd_idx  (s.idx),
    .rd_data (nvm_data)
  );

  pdrc_hard_req u_hard (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .reset_pin_low (reset_pin_low),
    .bit_strobe    (s.hard_bit),
    .req           (hard_req)
  );

  // ---------------------------------------------------------------
  // sequencer and register port
  // ---------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.ack      = 1'b0;
    next_s.burn     = 1'b0;
    next_s.hard_bit = 1'b0;
    next_s.realign  = 1'b0;
    case (s.state)
      pdrc_pkg::PDRC_LOAD: begin
        // copy the nvm image into the live registers, one per cycle;
        // the port is refused meanwhile so a write cannot be lost
        // under the reload
        next_s.regs[s.idx] = nvm_data;
        next_s.idx         = s.idx + 4'h1;
        if (s.idx == pdrc_pkg::IDX_LAST) begin
          next_s.state = pdrc_pkg::PDRC_ALIGN;
        end
      end
      pdrc_pkg::PDRC_ALIGN: begin
        next_s.realign = 1'b1;
        next_s.state   = pdrc_pkg::PDRC_RUN;
      end
      pdrc_pkg::PDRC_RUN: begin
        // port stays live whatever the sleep bit says
        if (reg_wr) begin
          next_s.ack = 1'b1;
          if (pdrc_is_page(reg_addr)) begin
            next_s.page = reg_wdata;
          end else if (burn_hit) begin
            // only the key arms a burn, any other value is dropped
            next_s.burn = (reg_wdata == pdrc_pkg::BURN_KEY);
          end else if (wr_dec[4]) begin
            next_s.regs[wr_dec[3:0]] = reg_wdata;
            if (wr_dec[3:0] == pdrc_pkg::IDX_SLEEP) begin
              // hard reset bit is a strobe, never stored
              next_s.regs[pdrc_pkg::IDX_SLEEP][pdrc_pkg::HARD_RST_BIT] =
                1'b0;
              next_s.hard_bit = reg_wdata[pdrc_pkg::HARD_RST_BIT];
            end
          end
        end else if (reg_rd) begin
          next_s.ack = 1'b1;
          if (pdrc_is_page(reg_addr)) begin
            next_s.rdata = s.page;
          end else if (rd_dec[4]) begin
            next_s.rdata = s.regs[rd_dec[3:0]];
          end else begin
            next_s.rdata = 8'h00;
          end
        end
      end
      default: begin
        next_s.state = pdrc_pkg::PDRC_LOAD;
      end
    endcase
    // pin or bit restarts the reload from the first entry
    if (hard_req) begin
      next_s.state = pdrc_pkg::PDRC_LOAD;
      next_s.idx   = 4'h0;
    end
    next_s.busy = (next_s.state != pdrc_pkg::PDRC_RUN);

    // power controls follow the registers one cycle after a write
    next_s.sleep  = next_s.regs[pdrc_pkg::IDX_SLEEP]
                               [pdrc_pkg::SLEEP_BIT];
    next_s.xo_pwr = next_s.regs[pdrc_pkg::IDX_XO]
                               [pdrc_pkg::XO_EN_BIT];
    next_s.in_en  = next_s.regs[pdrc_pkg::IDX_INEN]
                    [pdrc_pkg::IN_EN_LSB +: pdrc_pkg::NIN];
    // each driver off by its own bit or by the global bit
    for (int g = 0; g < pdrc_pkg::NOUT; g++) begin
      next_s.drv_off[g] =
        next_s.regs[pdrc_pkg::IDX_OUT0A + g][pdrc_pkg::DRV_OFF_BIT]
        | next_s.regs[pdrc_pkg::IDX_ALL][pdrc_pkg::ALL_OFF_BIT];
    end
    // base defaults reported by fixed settings
    next_s.xtal   = pdrc_pkg::XTAL_MHZ;
    next_s.io18   = pdrc_pkg::IO_1V8;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // one register stage for the whole state; reset sets every driver off,
  // but driver_off follows the live registers, cleared by reset, from the first load cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s.state    <= pdrc_pkg::PDRC_LOAD;
      s.idx      <= 4'h0;
      s.page     <= 8'h00;
      s.regs     <= '0;
      s.rdata    <= 8'h00;
      s.ack      <= 1'b0;
      s.burn     <= 1'b0;
      s.hard_bit <= 1'b0;
      s.drv_off  <= '1;
      s.sleep    <= 1'b0;
      s.xo_pwr   <= 1'b1;
      s.in_en    <= '0;
      s.realign  <= 1'b0;
      s.busy     <= 1'b1;
      s.xtal     <= pdrc_pkg::XTAL_MHZ;
      s.io18     <= pdrc_pkg::IO_1V8;
    end else begin
      s.state    <= next_s.state;
      s.idx      <= next_s.idx;
      s.page     <= next_s.page;
      s.regs     <= next_s.regs;
      s.rdata    <= next_s.rdata;
      s.ack      <= next_s.ack;
      s.burn     <= next_s.burn;
      s.hard_bit <= next_s.hard_bit;
      s.drv_off  <= next_s.drv_off;
      s.sleep    <= next_s.sleep;
      s.xo_pwr   <= next_s.xo_pwr;
      s.in_en    <= next_s.in_en;
      s.realign  <= next_s.realign;
      s.busy     <= next_s.busy;
      s.xtal     <= next_s.xtal;
      s.io18     <= next_s.io18;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign reg_rdata        = s.rdata;
  assign reg_ack          = s.ack;
  assign device_sleep_ctl = s.sleep;
  assign driver_off       = s.drv_off;
  assign xo_power         = s.xo_pwr;
  assign in_buf_en        = s.in_en;
  assign realign          = s.realign;
  assign load_busy        = s.busy;
  assign xtal_mhz         = s.xtal;
  assign io_1v8           = s.io18;

endmodule

`default_nettype wire

// ---- bench/pdrc_top_asserts.sv ----
// concurrent checks on the power-down and reset control ports
// assumes the bind below attaches it to every pdrc_top
`default_nettype none

module pdrc_top_checker (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic                      reset_pin_low,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      reg_ack,
  input wire logic                      device_sleep_ctl,
  input wire logic [pdrc_pkg::NOUT-1:0] driver_off,
  input wire logic                      xo_power,
  input wire logic [pdrc_pkg::NIN-1:0]  in_buf_en,
  input wire logic                      realign,
  input wire logic                      load_busy,
  input wire logic [7:0]                xtal_mhz,
  input wire logic                      io_1v8
);
  logic [7:0]  page_q;
  logic        wr_take;
  logic        rd_take;
  logic [15:0] full;
  logic        plain;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // taken requests and the page they land on
  assign wr_take = reg_wr && !load_busy;
  assign rd_take = reg_rd && !reg_wr && !load_busy;
  assign full    = {page_q, reg_addr};
  assign plain   = wr_take && !reg_wdata[1];

  // page as last written by the host
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) page_q <= 8'h00;
    else if (wr_take && reg_addr == 8'h01) page_q <= reg_wdata;
  end

  a_ack_taken: assert property (
    (reg_wr || reg_rd) && !load_busy |=> reg_ack)
    else $error("request taken without answer");
  a_ack_refused: assert property (
    (reg_wr || reg_rd) && load_busy |=> !reg_ack)
    else $error("request answered during load");
  a_sleep_follows: assert property (
    plain && full == 16'h001e |=>
      device_sleep_ctl == $past(reg_wdata[0]))
    else $error("sleep control does not follow write");
  a_all_off: assert property (
    wr_take && full == 16'h0145 && reg_wdata[0] |=> &driver_off)
    else $error("global off left a driver on");
  a_xo_follows: assert property (
    wr_take && full == 16'h090e |=> xo_power == $past(reg_wdata[1]))
    else $error("oscillator power does not follow write");
  a_inbuf_follows: assert property (
    wr_take && full == 16'h0949 |=>
      in_buf_en == $past(reg_wdata[3:0]))
    else $error("input buffers do not follow write");
  a_hard_reload: assert property (
    wr_take && full == 16'h001e && reg_wdata[1] |-> ##[1:3] load_busy)
    else $error("hard reset bit did not start a load");
  a_pin_reload: assert property (
    $fell(reset_pin_low) |-> ##[1:2] load_busy)
    else $error("reset pin did not start a load");
  a_realign_end: assert property (
    $fell(load_busy) |-> realign)
    else $error("load ended without realign pulse");
  a_page_read: assert property (
    rd_take && reg_addr == 8'h01 |=> reg_rdata == page_q)
    else $error("page read back wrong");
  a_base_consts: assert property (
    xtal_mhz == 8'h30 && io_1v8)
    else $error("base crystal or io setting wrong");
endmodule

bind pdrc_top pdrc_top_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_low(reset_pin_low),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .device_sleep_ctl(device_sleep_ctl), .driver_off(driver_off),
  .xo_power(xo_power), .in_buf_en(in_buf_en), .realign(realign),
  .load_busy(load_busy), .xtal_mhz(xtal_mhz), .io_1v8(io_1v8));

`default_nettype wire

// ---- bench/pdrc_host.sv ----
// host controller model for the paged register port
// assumes requests are launched on the falling edge of clk_sys
`default_nettype none

module pdrc_host (
  input  wire logic       clk_sys,
  input  wire logic       reg_ack,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reset_pin_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reset_pin_low = 1'b1;
  end

  // one-cycle request, answer taken one cycle later
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    @(negedge clk_sys);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    {reg_addr, reg_wdata} = ~{a, d};
    ok = reg_ack;
    q = reg_rdata;
  endtask

  // page select first, then the access itself
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    logic ok1;
    xfer(1'b1, pdrc_pkg::PAGE_OFS, a[15:8], q, ok1);
    xfer(wr, a[7:0], d, q, ok);
    ok = ok & ok1;
  endtask

  // hard reset request through the pin
  task automatic pin_reset();
    @(negedge clk_sys);
    reset_pin_low = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_pin_low = 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- bench/power_down_and_reset_control_test.sv ----
// self-checking bench for the power-down and reset control block
// assumes pdrc_host as host model and the bound port checker
`default_nettype none

module power_down_and_reset_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        rst_n;
  logic        reset_pin_low;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_ack;
  logic        device_sleep_ctl;
  logic [11:0] driver_off;
  logic        xo_power;
  logic [3:0]  in_buf_en;
  logic        realign;
  logic        load_busy;
  logic [7:0]  xtal_mhz;
  logic        io_1v8;
  int          failures;
  int          n_compared;

  pdrc_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_low(reset_pin_low),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .device_sleep_ctl(device_sleep_ctl), .driver_off(driver_off),
    .xo_power(xo_power), .in_buf_en(in_buf_en), .realign(realign),
    .load_busy(load_busy), .xtal_mhz(xtal_mhz), .io_1v8(io_1v8));

  pdrc_host host (
    .clk_sys(clk_sys), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reset_pin_low(reset_pin_low));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [10:0] e, logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic chk_drv(logic [pdrc_pkg::NOUT-1:0] e);
    n_compared++;
    if (driver_off !== e) begin
      failures++;
      $display("unexpected driver_off: expected %h, seen %h", e,
               driver_off);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    host.access(1'b1, a, d, q, ok);
    chk("write answer", 11'h001, {10'h000, ok});
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host.access(1'b0, a, 8'h00, q, ok);
    chk("read answer", 11'h001, {10'h000, ok});
    chk($sformatf("read data %h", a), {3'b000, e}, {3'b000, q});
  endtask

  // bounded wait for a load to start and end, realign seen as it ends
  task automatic wait_ready();
    int n;
    n = 0;
    while (load_busy !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    for (int k = 0; k < 100 && n < 8; k++) begin
      @(negedge clk_sys);
      if (load_busy === 1'b0) begin
        chk("realign", 11'h001, {10'h000, realign});
        return;
      end
    end
    failures++;
    report_and_stop();
  endtask

  // base image as the host sees it after power-up
  function automatic logic [7:0] base_val(int i);
    if (i == 0 || i == 13) return 8'h00;
    if (i <= 12) return 8'h01;
    return (i == 14) ? 8'h02 : 8'h0f;
  endfunction

  logic [7:0] q;
  logic       ok;

  initial begin
    rst_n = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    wait_ready();
    chk_drv('1);
    chk("xtal_mhz", 11'h030, {3'b000, xtal_mhz});
    chk("io_1v8", 11'h001, {10'h000, io_1v8});
    chk("xo_power", 11'h001, {10'h000, xo_power});
    chk("sleep", 11'h000, {10'h000, device_sleep_ctl});
    for (int i = 0; i < pdrc_pkg::NREG; i++) begin
      rd(pdrc_pkg::REG_ADDR[i], base_val(i));
    end
    rd(16'h0150, 8'h00);
    rd(16'h0901, 8'h09);
    for (int i = 1; i <= pdrc_pkg::NOUT; i++) begin
      wr(pdrc_pkg::REG_ADDR[i], 8'h00);
    end
    chk_drv('0);
    for (int k = 0; k < pdrc_pkg::NOUT; k++) begin
      wr(pdrc_pkg::REG_ADDR[k+1], 8'h01);
      chk_drv(12'h001 << k);
      wr(pdrc_pkg::REG_ADDR[k+1], 8'h00);
    end
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_ALL], 8'h01);
    chk_drv('1);
    rd(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_ALL], 8'h01);
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_ALL], 8'h00);
    chk_drv('0);
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h00);
    chk("xo_power", 11'h000, {10'h000, xo_power});
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h02);
    chk("xo_power", 11'h001, {10'h000, xo_power});
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_INEN], 8'h05);
    chk("in_buf_en", 11'h005, {7'h00, in_buf_en});
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_INEN], 8'h0a);
    chk("in_buf_en", 11'h00a, {7'h00, in_buf_en});
    // port keeps working while asleep
    wr(16'h001e, 8'h01);
    chk("sleep", 11'h001, {10'h000, device_sleep_ctl});
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h00);
    rd(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h00);
    wr(16'h001e, 8'h00);
    chk("sleep", 11'h000, {10'h000, device_sleep_ctl});
    // save, spoil, then reload by bit and by pin
    wr(pdrc_pkg::BURN_ADDR, pdrc_pkg::BURN_KEY);
    rd(pdrc_pkg::BURN_ADDR, 8'h00);
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h02);
    wr(16'h001e, 8'h02);
    wait_ready();
    rd(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_XO], 8'h00);
    chk_drv('0);
    wr(pdrc_pkg::REG_ADDR[pdrc_pkg::IDX_INEN], 8'h03);
    host.pin_reset();
    host.xfer(1'b1, 8'h01, 8'h00, q, ok);
    chk("refused answer", 11'h000, {10'h000, ok});
    wait_ready();
    chk("in_buf_en", 11'h00a, {7'h00, in_buf_en});
    report_and_stop();
  end
endmodule

`default_nettype wire
